// File: rtl/quad_dac_load.sv
// converter end: shift register, address decode, channel registers
`timescale 1ns/10ps
`include "quad_dac_params.svh"
// What this block and the serial master do
// (RL1) sixteen bit shift register, first bit MSB
// (RL2) shift on rising clock while select low
// (RL3) word: address, two spare, twelve code bits
// (RL4) address picks channel A to D
// (RL5) master strobes load after sixteen bits
// (RL6) load strobe copies word to addressed channel
// (RL7) master shifts nothing while load held low
// (RL8) shift clock is select OR serial clock
// (RL9) master parks clock high around frame edges
// (RL10) clear loads zero or midscale per select
// (RL11) clear ignores select, else no change
// (RL12) clear value holds until next load strobe
// (RL13) code is straight binary, 4096 steps
// (RL14) extra edges keep newest sixteen bits
module quad_dac_load (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  quad_dac_link_if.dev               link,
  output logic [`CODE_BITS-1:0]      chan_a_code,
  output logic [`CODE_BITS-1:0]      chan_b_code,
  output logic [`CODE_BITS-1:0]      chan_c_code,
  output logic [`CODE_BITS-1:0]      chan_d_code,
  output quad_dac_pkg::word_type     input_word
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0]              cs_s_q;
  logic [1:0]              sclk_s_q;
  logic [1:0]              data_s_q;
  logic [1:0]              load_s_q;
  logic [1:0]              clr_s_q;
  logic [1:0]              sel_s_q;
  logic                    shclk;
  logic                    shclk_prev_q;
  logic                    load_prev_q;
  logic                    shift_edge;
  logic                    load_fall;
  logic [3:0]              load_hit;
  quad_dac_pkg::word_type  shift_q;
  quad_dac_pkg::code_type  chan_q [4];
  quad_dac_pkg::chan_type  addr;
  quad_dac_pkg::code_type  word_code;
  quad_dac_pkg::code_type  clear_code;

  // two-flop synchronisers, one per pin, reset to the pin's idle level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_s_q <= `SYNC_IDLE_HIGH;
    end else begin
      cs_s_q <= {cs_s_q[0], link.cs_n};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_s_q <= `SYNC_IDLE_HIGH;
    end else begin
      sclk_s_q <= {sclk_s_q[0], link.sclk};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_s_q <= `SYNC_IDLE_LOW;
    end else begin
      data_s_q <= {data_s_q[0], link.serial_in};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      load_s_q <= `SYNC_IDLE_HIGH;
    end else begin
      load_s_q <= {load_s_q[0], link.load_strobe_n};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clr_s_q <= `SYNC_IDLE_HIGH;
    end else begin
      clr_s_q <= {clr_s_q[0], link.clear_n};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_s_q <= `SYNC_IDLE_LOW;
    end else begin
      sel_s_q <= {sel_s_q[0], link.clear_level_select};
    end
  end

  // or'ed after syncing, so a select rise with the clock low is an edge
  assign shclk = cs_s_q[1] | sclk_s_q[1]; // RL8

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shclk_prev_q <= 1'b1;
    end else begin
      shclk_prev_q <= shclk;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      load_prev_q <= 1'b1;
    end else begin
      load_prev_q <= load_s_q[1];
    end
  end

  assign shift_edge = shclk & ~shclk_prev_q;
  assign load_fall  = ~load_s_q[1] & load_prev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // shift register, MSB first, oldest bits fall off the top
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_q <= 16'h0000;
    end else if (shift_edge) begin
      shift_q <= {shift_q[`WORD_BITS-2:0], data_s_q[1]}; // RL1 RL2 RL3 RL14
    end
  end

  assign addr      = {shift_q[`ADDR_HI_POS], shift_q[`ADDR_LO_POS]}; // RL3
  assign word_code = shift_q[`CODE_MSB_POS:0]; // RL13

  // zero or midscale while clear is low
  always_comb begin
    clear_code = `ZERO_SCALE_CODE;
    if (sel_s_q[1]) begin
      clear_code = `MID_SCALE_CODE;
    end
  end

  // one-hot channel pick from the two address bits
  always_comb begin
    load_hit = 4'h0;
    if (load_fall) begin
      unique case (addr)
        2'h0: load_hit = 4'h1; // RL4
        2'h1: load_hit = 4'h2; // RL4
        2'h2: load_hit = 4'h4; // RL4
        2'h3: load_hit = 4'h8; // RL4
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel registers; clear dominates, load on strobe fall
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_n) begin
        chan_q[i] <= `CHAN_RESET_CODE;
      end else if (!clr_s_q[1]) begin
        chan_q[i] <= clear_code; // RL10 RL11
      end else if (load_hit[i]) begin
        chan_q[i] <= word_code; // RL6 RL12
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registered outputs, one flop stage after the channel and shift registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chan_a_code <= `CHAN_RESET_CODE;
    end else begin
      chan_a_code <= chan_q[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chan_b_code <= `CHAN_RESET_CODE;
    end else begin
      chan_b_code <= chan_q[1];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chan_c_code <= `CHAN_RESET_CODE;
    end else begin
      chan_c_code <= chan_q[2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chan_d_code <= `CHAN_RESET_CODE;
    end else begin
      chan_d_code <= chan_q[3];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      input_word <= 16'h0000;
    end else begin
      input_word <= shift_q;
    end
  end
endmodule

// File: rtl/quad_dac_params.svh
// constants for the quad converter serial load path
`ifndef QUAD_DAC_PARAMS_SVH
`define QUAD_DAC_PARAMS_SVH
`define WORD_BITS        16
`define CODE_BITS        12
`define ADDR_HI_POS      15
`define ADDR_LO_POS      14
`define CODE_MSB_POS     11
`define ZERO_SCALE_CODE  12'h000
`define MID_SCALE_CODE   12'h800
`define CHAN_RESET_CODE  12'h000
`define SCLK_HALF_CYCLES 16
`define HOLD_CYCLES      8
`define SYNC_IDLE_HIGH   2'h3
`define SYNC_IDLE_LOW    2'h0
`endif

// File: rtl/quad_dac_pkg.sv
// types shared by both ends of the serial load link
package quad_dac_pkg;
  typedef logic [15:0] word_type;
  typedef logic [11:0] code_type;
  typedef logic [1:0]  chan_type;
endpackage

// File: rtl/quad_dac_link_if.sv
// link wires between serial master and converter load path
`timescale 1ns/10ps
interface quad_dac_link_if;
  logic cs_n;
  logic sclk;
  logic serial_in;
  logic load_strobe_n;
  logic clear_n;
  logic clear_level_select;
  modport dev (input cs_n, input sclk, input serial_in, input load_strobe_n, input clear_n,
               input clear_level_select);
  modport master (output cs_n, output sclk, output serial_in, output load_strobe_n, output clear_n,
                  output clear_level_select);
endinterface

// File: rtl/quad_dac_master.sv
// serial master end: sends one word, strobes load, drives clear
`timescale 1ns/10ps
`include "quad_dac_params.svh"
module quad_dac_master (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  quad_dac_link_if.master            link,
  input  wire logic                  send_req,
  input  wire quad_dac_pkg::chan_type send_chan,
  input  wire quad_dac_pkg::code_type send_code,
  input  wire logic                  clear_req,
  input  wire logic                  clear_mid,
  output logic                       busy
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_LOW   = 3'b010,
    ST_HIGH  = 3'b011,
    ST_END   = 3'b100,
    ST_LOAD  = 3'b101,
    ST_GAP   = 3'b110
  } state_type;

  state_type               state_q;
  quad_dac_pkg::word_type  word_q;
  logic [4:0]              bit_q;
  logic [5:0]              cnt_q;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      word_q  <= 16'h0000;
      bit_q   <= 5'h00;
      cnt_q   <= 6'h00;
      busy    <= 1'b0;
      link.cs_n          <= 1'b1;
      link.sclk          <= 1'b1;
      link.serial_in     <= 1'b0;
      link.load_strobe_n <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 6'h01;
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= 6'h00;
          if (send_req) begin
            word_q  <= {send_chan, 2'b00, send_code}; // RL3
            bit_q   <= 5'h00;
            busy    <= 1'b1;
            link.cs_n <= 1'b0; // RL9
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: if (cnt_q == 6'(`SCLK_HALF_CYCLES - 1)) begin
          link.sclk      <= 1'b0;
          link.serial_in <= word_q[`WORD_BITS-1];
          word_q  <= {word_q[`WORD_BITS-2:0], 1'b0};
          cnt_q   <= 6'h00;
          state_q <= ST_LOW;
        end
        ST_LOW: if (cnt_q == 6'(`SCLK_HALF_CYCLES - 1)) begin
          link.sclk <= 1'b1;
          bit_q   <= bit_q + 5'h01;
          cnt_q   <= 6'h00;
          state_q <= ST_HIGH;
        end
        ST_HIGH: if (cnt_q == 6'(`SCLK_HALF_CYCLES - 1)) begin
          cnt_q <= 6'h00;
          if (bit_q == 5'(`WORD_BITS)) begin
            link.cs_n <= 1'b1; // RL9
            state_q <= ST_END;
          end else begin
            link.sclk      <= 1'b0;
            link.serial_in <= word_q[`WORD_BITS-1];
            word_q  <= {word_q[`WORD_BITS-2:0], 1'b0};
            state_q <= ST_LOW;
          end
        end
        ST_END: if (cnt_q == 6'(`HOLD_CYCLES - 1)) begin
          link.load_strobe_n <= 1'b0; // RL5
          cnt_q   <= 6'h00;
          state_q <= ST_LOAD;
        end
        ST_LOAD: if (cnt_q == 6'(`HOLD_CYCLES - 1)) begin
          link.load_strobe_n <= 1'b1;
          cnt_q   <= 6'h00;
          state_q <= ST_GAP;
        end
        ST_GAP: if (cnt_q == 6'(`HOLD_CYCLES - 1)) begin
          busy    <= 1'b0; // RL7
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link.clear_n            <= 1'b1;
      link.clear_level_select <= 1'b0;
    end else begin
      link.clear_n            <= ~clear_req;
      link.clear_level_select <= clear_mid;
    end
  end
endmodule

// File: test/quad_dac_link_props.sv
// protocol checks on the serial load link wires
`timescale 1ns/10ps
module quad_dac_link_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic load_strobe_n,
  input wire logic clear_n,
  input wire logic clear_level_select
);
  logic [4:0] cnt_q;
  logic       sclk_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence load_pulse;
    !load_strobe_n [*8] ##1 load_strobe_n;
  endsequence
  sequence sclk_low_half;
    !sclk [*8] ##8 !sclk ##1 sclk;
  endsequence
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
  end
  // rising serial clock edges within one frame
  always_ff @(posedge clk) begin
    if (!rst_n || cs_n) cnt_q <= 5'h00;
    else if (sclk && !sclk_q) cnt_q <= cnt_q + 5'h01;
  end
  ////////////////////////////////////////////////////////////
  chk_load_idle_only: assert property (!load_strobe_n |-> cs_n && sclk)
    else $error("load strobe during frame");
  chk_load_width: assert property ($fell(load_strobe_n) |-> load_pulse)
    else $error("load strobe width wrong");
  chk_cs_to_load: assert property ($rose(cs_n) |-> load_strobe_n [*8] ##1 !load_strobe_n)
    else $error("load strobe spacing wrong");
  chk_cs_rise_high: assert property ($rose(cs_n) |-> sclk)
    else $error("select rose with clock low");
  chk_cs_fall_high: assert property ($fell(cs_n) |-> sclk)
    else $error("select fell with clock low");
  chk_sclk_idle: assert property (cs_n |-> sclk)
    else $error("clock low outside frame");
  chk_sclk_half: assert property ($fell(sclk) |-> sclk_low_half)
    else $error("clock low phase wrong");
  chk_word_bits: assert property ($rose(cs_n) |-> cnt_q == 5'h10)
    else $error("frame not sixteen bits");
  chk_load_gap: assert property ($rose(load_strobe_n) |-> cs_n [*8])
    else $error("frame too soon after load");
endmodule

// File: test/test_quad_dac_serial_load.sv
// self-checking bench for both ends of the serial load link
`timescale 1ns/10ps
module test_quad_dac_serial_load;
  logic                   clk, rst_n, send_req, clear_req, clear_mid, busy;
  quad_dac_pkg::chan_type send_chan;
  quad_dac_pkg::code_type send_code, chan_a_code, chan_b_code, chan_c_code, chan_d_code;
  quad_dac_pkg::word_type input_word;
  quad_dac_pkg::code_type exp_code [4];
  quad_dac_pkg::code_type codes [4] = '{12'hFFF, 12'h001, 12'h800, 12'h7FE};
  int                     err_total, checked;
  quad_dac_link_if link_i ();
  quad_dac_master u_quad_dac_master (.clk(clk), .rst_n(rst_n), .link(link_i), .send_req(send_req),
    .send_chan(send_chan), .send_code(send_code), .clear_req(clear_req), .clear_mid(clear_mid), .busy(busy));
  quad_dac_load u_quad_dac_load (.clk(clk), .rst_n(rst_n), .link(link_i), .chan_a_code(chan_a_code),
    .chan_b_code(chan_b_code), .chan_c_code(chan_c_code), .chan_d_code(chan_d_code), .input_word(input_word));
  quad_dac_link_props u_quad_dac_link_props (.clk(clk), .rst_n(rst_n), .cs_n(link_i.cs_n), .sclk(link_i.sclk),
    .serial_in(link_i.serial_in), .load_strobe_n(link_i.load_strobe_n), .clear_n(link_i.clear_n),
    .clear_level_select(link_i.clear_level_select));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task check_chans;
    check({4'h0, chan_a_code}, {4'h0, exp_code[0]});
    check({4'h0, chan_b_code}, {4'h0, exp_code[1]});
    check({4'h0, chan_c_code}, {4'h0, exp_code[2]});
    check({4'h0, chan_d_code}, {4'h0, exp_code[3]});
  endtask
  task send(input logic [1:0] ch, input logic [11:0] code);
    int n;
    @(negedge clk);
    send_req = 1'h1;
    send_chan = ch;
    send_code = code;
    @(negedge clk);
    send_req = 1'h0;
    n = 0;
    while (busy !== 1'h0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check({15'h0000, busy}, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////
  task addr_scenario;
    for (int i = 0; i < 4; i++) begin
      exp_code[i] = codes[i];
      send(i[1:0], codes[i]);
      check(input_word, {i[1:0], 2'h0, codes[i]});
      check_chans;
    end
  endtask
  task clear_scenario(input logic mid);
    logic [11:0] v;
    v = mid ? 12'h800 : 12'h000;
    @(negedge clk);
    clear_mid = mid;
    clear_req = 1'h1;
    repeat (8) @(negedge clk);
    exp_code = '{v, v, v, v};
    check_chans;
    clear_req = 1'h0;
    repeat (8) @(negedge clk);
    check_chans;
    exp_code[1] = 12'h5A3;
    send(2'h1, 12'h5A3);
    check_chans;
  endtask
  task clear_frame_scenario;
    @(negedge clk);
    send_req = 1'h1;
    send_chan = 2'h3;
    send_code = 12'h3C5;
    @(negedge clk);
    send_req = 1'h0;
    repeat (100) @(negedge clk);
    clear_mid = 1'h1;
    clear_req = 1'h1;
    repeat (8) @(negedge clk);
    exp_code = '{12'h800, 12'h800, 12'h800, 12'h800};
    check({15'h0000, link_i.cs_n}, 16'h0000);
    check_chans;
    clear_req = 1'h0;
    repeat (600) @(negedge clk);
    exp_code[3] = 12'h3C5;
    check({15'h0000, busy}, 16'h0000);
    check(input_word, 16'hC3C5);
    check_chans;
  endtask
  task results;
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'h0;
    send_req = 1'h0;
    send_chan = 2'h0;
    send_code = 12'h000;
    clear_req = 1'h0;
    clear_mid = 1'h0;
    err_total = 0;
    checked = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    exp_code = '{12'h000, 12'h000, 12'h000, 12'h000};
    repeat (4) @(negedge clk);
    check_chans;
    addr_scenario;
    clear_scenario(1'h1);
    clear_scenario(1'h0);
    clear_frame_scenario;
    results;
  end
  initial begin
    #50000;
    err_total++;
    results;
  end
endmodule
